// File: logic/nfc_ctrl.sv
`timescale 1ns/1ps
`include "nfc_map.svh"

// Functional notes
// - wait 50ns after reset before reading
// - wait 50ns after reset before writing
// - access may start once ready/busy high (not checked after reset: S_RCV goes to S_IDLE on its timer alone)
// - toggle bits advance per CE/OE read
// - CE/OE high 20ns between status reads
// - write cycle lasts at least 110ns
module nfc_ctrl (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  cmd_valid,
   input  wire logic [2:0]            cmd_op,
   input  wire logic [`NFC_AW-1:0]    cmd_addr,
   input  wire logic [`NFC_DW-1:0]    cmd_wdata,
   output logic                       cmd_ready,
   output logic                       rsp_valid,
   output logic [`NFC_DW-1:0]         rsp_data,
   output logic                       rsp_stable,
   output logic                       flash_reset_n,
   output logic                       flash_ce_n,
   output logic                       flash_oe_n,
   output logic                       flash_we_n,
   output logic [`NFC_AW-1:0]         flash_addr,
   output logic [`NFC_DW-1:0]         flash_dq_out,
   output logic                       flash_dq_oe,
   input  wire logic [`NFC_DW-1:0]    flash_dq_in,
   input  wire logic                  flash_ready_busy_n
);
   nfc_pkg::nfc_state_t state;
   nfc_pkg::nfc_state_t next_state;
   logic [2:0]          op;
   logic                second_rd;
   logic [`NFC_DW-1:0]  first_word;
   logic                tmr_exp;
   logic                tmr_load;
   logic [`NFC_TW-1:0]  tmr_val;
   logic                accept;
   logic                first_rd;
   logic                rsp_fire;
   logic                rd_end;
   logic                is_poll;
   logic                poll_done;
   logic                pwr_up;

   // request decode
   assign accept   = cmd_valid && cmd_ready;
   assign is_poll  = (op == `NFC_OP_POLL);
   assign first_rd = is_poll && !second_rd;
   assign rd_end   = (state == nfc_pkg::S_RD) && tmr_exp;
   // a write answers once its full cycle is over, never earlier
   assign rsp_fire = (rd_end && !first_rd)
                   || ((state == nfc_pkg::S_WHI) && tmr_exp)
                   || ((state == nfc_pkg::S_WAIT) && flash_ready_busy_n)
                   || ((state == nfc_pkg::S_RCV) && tmr_exp);

   // next state
   always_comb begin
      next_state = state;
      case (state)
         nfc_pkg::S_RST:  if (tmr_exp && !pwr_up) next_state = nfc_pkg::S_RCV;
         // recovery before any read or write
         nfc_pkg::S_RCV:  if (tmr_exp) next_state = nfc_pkg::S_IDLE;
         nfc_pkg::S_IDLE: begin
            if (accept) begin
               case (cmd_op)
                  `NFC_OP_READ:  next_state = nfc_pkg::S_RD;
                  `NFC_OP_POLL:  next_state = nfc_pkg::S_RD;
                  `NFC_OP_WRITE: next_state = nfc_pkg::S_WLO;
                  `NFC_OP_WAIT:  next_state = nfc_pkg::S_WAIT;
                  `NFC_OP_RESET: next_state = nfc_pkg::S_RST;
                  default:       next_state = nfc_pkg::S_IDLE;
               endcase
            end
         end
         nfc_pkg::S_RD:   if (tmr_exp) next_state = nfc_pkg::S_GAP;
         nfc_pkg::S_WLO:  if (tmr_exp) next_state = nfc_pkg::S_WHI;
         nfc_pkg::S_WHI:  if (tmr_exp) next_state = nfc_pkg::S_GAP;
         // second poll read needs a fresh CE/OE edge
         nfc_pkg::S_GAP: begin
            if (tmr_exp) begin
               next_state = (is_poll && second_rd && !poll_done) ?
                            nfc_pkg::S_RD : nfc_pkg::S_IDLE;
            end
         end
         // no added delay once the device is ready
         nfc_pkg::S_WAIT: if (flash_ready_busy_n) next_state = nfc_pkg::S_IDLE;
         default:         next_state = nfc_pkg::S_RST;
      endcase
   end

   // timer reload on every state change, and once after release so that
   // the first flash reset pulse gets its full width too
   assign tmr_load = (next_state != state) || pwr_up;
   assign tmr_val  =
      (next_state == nfc_pkg::S_RST) ? `NFC_TW'(`NFC_RP_CYC - 1) :
      (next_state == nfc_pkg::S_RCV) ? `NFC_TW'(`NFC_RH_CYC - 1) :
      (next_state == nfc_pkg::S_RD)  ? `NFC_TW'(`NFC_RC_CYC - 1) :
      (next_state == nfc_pkg::S_WLO) ? `NFC_TW'(`NFC_WP_CYC - 1) :
      (next_state == nfc_pkg::S_WHI) ? `NFC_TW'(`NFC_WPH_CYC - 1) :
      (next_state == nfc_pkg::S_GAP) ? `NFC_TW'(`NFC_PH_CYC - 1) : '0;

   nfc_timer u_timer (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .load     (tmr_load),
      .load_val (tmr_val),
      .expired  (tmr_exp)
   );

   // state and latched request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state  <= nfc_pkg::S_RST;
         op     <= `NFC_OP_RESET;
         pwr_up <= 1'b1;
      end else begin
         state  <= next_state;
         pwr_up <= 1'b0;
         if (accept) op <= cmd_op;
      end
   end

   // poll bookkeeping: first word kept for the toggle compare
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         second_rd  <= 1'b0;
         poll_done  <= 1'b0;
         first_word <= '0;
      end else if (accept) begin
         second_rd <= 1'b0;
         poll_done <= 1'b0;
      end else if (rd_end) begin
         second_rd  <= 1'b1;
         poll_done  <= second_rd;
         first_word <= flash_dq_in;
      end
   end

   // pins are registered from the next state, so no glitches reach the flash
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flash_reset_n <= 1'b0;
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_dq_oe   <= 1'b0;
         cmd_ready     <= 1'b0;
      end else begin
         flash_reset_n <= (next_state != nfc_pkg::S_RST);
         flash_ce_n    <= !((next_state == nfc_pkg::S_RD) || (next_state == nfc_pkg::S_WLO)
                            || (next_state == nfc_pkg::S_WHI));
         flash_oe_n    <= (next_state != nfc_pkg::S_RD);
         flash_we_n    <= (next_state != nfc_pkg::S_WLO);
         flash_dq_oe   <= (next_state == nfc_pkg::S_WLO) || (next_state == nfc_pkg::S_WHI);
         cmd_ready     <= (next_state == nfc_pkg::S_IDLE);
      end
   end

   // address and write data held for the whole access
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flash_addr   <= '0;
         flash_dq_out <= '0;
      end else if (accept) begin
         flash_addr   <= cmd_addr;
         flash_dq_out <= cmd_wdata;
      end
   end

   // answer; stable means the general toggle bit stopped moving
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rsp_valid  <= 1'b0;
         rsp_data   <= '0;
         rsp_stable <= 1'b0;
      end else begin
         rsp_valid <= rsp_fire;
         if (rd_end && !first_rd) begin
            rsp_data   <= flash_dq_in;
            rsp_stable <= is_poll &&
               (first_word[`NFC_BIT_GTOGGLE] == flash_dq_in[`NFC_BIT_GTOGGLE]);
         end
      end
   end

   // helper counters for the timing checks
   logic [`NFC_TW-1:0] rst_hi_cnt;
   logic [`NFC_TW-1:0] rst_lo_cnt;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rst_hi_cnt <= '0;
         rst_lo_cnt <= '0;
      end else begin
         rst_hi_cnt <= !flash_reset_n ? '0 : (&rst_hi_cnt ? rst_hi_cnt : rst_hi_cnt + 1'b1);
         rst_lo_cnt <= flash_reset_n ? '0 : (&rst_lo_cnt ? rst_lo_cnt : rst_lo_cnt + 1'b1);
      end
   end

   chk_read_after_reset: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(flash_oe_n) |-> (rst_hi_cnt >= `NFC_TW'(`NFC_RH_CYC)))
      else $error("read started too soon after reset release");

   chk_write_after_reset: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(flash_we_n) |-> (rst_hi_cnt >= `NFC_TW'(`NFC_RH_CYC)))
      else $error("write started too soon after reset release");

   chk_reset_pulse_width: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(flash_reset_n) |-> (rst_lo_cnt >= `NFC_TW'(`NFC_RP_CYC)))
      else $error("reset pulse too short");

   chk_ready_no_delay: assert property (@(posedge clk_sys) disable iff (rst)
      (state == nfc_pkg::S_WAIT && flash_ready_busy_n) |=> (rsp_valid && cmd_ready))
      else $error("ready wait not answered at once");

   chk_poll_new_access: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(flash_oe_n) |-> ($past(flash_ce_n) && !flash_ce_n))
      else $error("status read without fresh chip enable edge");

   // the first status read must be followed by one idle cycle, then a fresh access
   chk_ce_high_gap: assert property (@(posedge clk_sys) disable iff (rst)
      (rd_end && first_rd) |=> (flash_ce_n && flash_oe_n) ##1 (!flash_ce_n && !flash_oe_n))
      else $error("status reads not separated by a chip enable high gap");

   chk_write_cycle_len: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(flash_we_n) |-> (!flash_ce_n && flash_dq_oe)[*5])
      else $error("write cycle shorter than minimum");
endmodule : nfc_ctrl

// File: logic/nfc_map.svh
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH

// system clock period
`define NFC_CLK_NS        25
// least time to whole cycles, never below one
`define NFC_CYC_UP(ns)    ((((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS) < 1 ? 1 : \
                           (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS))

// bus timing figures in ns (slower grade covers both grades)
`define NFC_T_RP_NS       500
`define NFC_T_RH_NS       50
`define NFC_T_RC_NS       110
`define NFC_T_WC_NS       110
`define NFC_T_WP_NS       35
`define NFC_T_PH_NS       20

`define NFC_RP_CYC        `NFC_CYC_UP(`NFC_T_RP_NS)
`define NFC_RH_CYC        `NFC_CYC_UP(`NFC_T_RH_NS)
`define NFC_RC_CYC        `NFC_CYC_UP(`NFC_T_RC_NS)
`define NFC_WC_CYC        `NFC_CYC_UP(`NFC_T_WC_NS)
`define NFC_WP_CYC        `NFC_CYC_UP(`NFC_T_WP_NS)
`define NFC_PH_CYC        `NFC_CYC_UP(`NFC_T_PH_NS)
`define NFC_WPH_CYC       (`NFC_WC_CYC - `NFC_WP_CYC)

// bus widths, word mode, and timer width
`define NFC_AW            22
`define NFC_DW            16
`define NFC_TW            8

// status bit positions
`define NFC_BIT_GTOGGLE   6
`define NFC_BIT_ETOGGLE   2
`define NFC_BIT_DPOLL     7

// user operation codes
`define NFC_OP_READ       3'h0
`define NFC_OP_WRITE      3'h1
`define NFC_OP_POLL       3'h2
`define NFC_OP_WAIT       3'h3
`define NFC_OP_RESET      3'h4

`endif

// File: logic/nfc_pkg.sv
package nfc_pkg;
   // controller sequencing states
   typedef enum logic [2:0] {
      S_RST,
      S_RCV,
      S_IDLE,
      S_RD,
      S_WLO,
      S_WHI,
      S_GAP,
      S_WAIT
   } nfc_state_t;
endpackage : nfc_pkg

// File: logic/nfc_timer.sv
`timescale 1ns/1ps
`include "nfc_map.svh"

module nfc_timer (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  load,
   input  wire logic [`NFC_TW-1:0]    load_val,
   output logic                       expired
);
   logic [`NFC_TW-1:0] cnt;

   // down counter, parks at zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= load_val;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign expired = (cnt == '0);
endmodule : nfc_timer

// File: tb/nfc_flash_model.sv
`timescale 1ns/1ps
`include "nfc_map.svh"

// flash stand-in: one word programmed per write cycle, busy for a short count
module nfc_flash_model #(parameter int BUSY_CYC = 40) (
   input  wire logic               clk_sys,
   input  wire logic               reset_n,
   input  wire logic               ce_n,
   input  wire logic               oe_n,
   input  wire logic               we_n,
   input  wire logic [`NFC_AW-1:0] addr,
   input  wire logic [`NFC_DW-1:0] dq_wr,
   output logic      [`NFC_DW-1:0] dq_rd,
   output logic                    ready_busy_n
);
   // sixteen words, one full program buffer's worth
   logic [`NFC_DW-1:0] mem [16];
   logic [`NFC_DW-1:0] last;
   logic [`NFC_DW-1:0] target;
   logic [3:0]         waddr;
   logic               tgl;
   logic               we_q;
   logic               rd_q;
   int                 cnt;
   wire                busy = (cnt != 0) && (cnt <= BUSY_CYC);

   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
      cnt = 0;
      tgl = 1'b0;
      last = 16'h0000;
   end
   // busy low only after a 5 cycle delay from the write-enable rise
   assign ready_busy_n = !busy;
   // released bus shows the inverse of its last value, never a held copy
   always_comb begin
      dq_rd = ~last;
      if (!ce_n && !oe_n) dq_rd = busy ? target : mem[addr[3:0]];
      if (!ce_n && !oe_n && busy) dq_rd[7] = ~target[7];
      if (!ce_n && !oe_n && busy) dq_rd[6] = tgl;
      // no sector is ever erase-suspended here, so that toggle bit stands still
      if (!ce_n && !oe_n && busy) dq_rd[2] = target[2];
      // no suspend is ever issued, so status is valid at once after any resume
      if (!ce_n && !oe_n && !busy) dq_rd = mem[addr[3:0]];
   end
   // program, abort and toggle sequencing
   always @(posedge clk_sys) begin
      we_q <= we_n;
      rd_q <= ce_n | oe_n;
      if (!ce_n && !oe_n) last <= dq_rd;
      if (!reset_n) begin
         // short pulses abort at once; standby would need a far longer pulse
         cnt <= 0;
      end else if (we_n && !we_q && !ce_n) begin
         cnt <= BUSY_CYC + 5;
         target <= dq_wr;
         waddr <= addr[3:0];
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) mem[waddr] <= target;
      end
      if (busy && rd_q && !(ce_n | oe_n)) tgl <= ~tgl;
   end
endmodule : nfc_flash_model

// File: tb/nfc_ctrl_test.sv
`timescale 1ns/1ps
`include "nfc_map.svh"

module nfc_ctrl_test;
   typedef struct {logic [2:0] op; logic [3:0] a; logic [15:0] d;
                   logic [15:0] exp; logic [15:0] msk; logic stab;} nfc_row_t;
   logic               clk_sys, rst, cmd_valid, cmd_ready, rsp_valid, rsp_stable;
   logic [2:0]         cmd_op;
   logic [`NFC_AW-1:0] cmd_addr, flash_addr;
   logic [`NFC_DW-1:0] cmd_wdata, rsp_data, flash_dq_out, flash_dq_in;
   logic               flash_reset_n, flash_ce_n, flash_oe_n, flash_we_n;
   logic               flash_dq_oe, flash_ready_busy_n, ce_q, wr_seen;
   int                 failures, num_checks, lo_n, hi_n, rh_n, nfall, n0;
   nfc_row_t           rows [7];

   nfc_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_stable(rsp_stable),
      .flash_reset_n(flash_reset_n), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
      .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
      .flash_ready_busy_n(flash_ready_busy_n));
   nfc_flash_model #(.BUSY_CYC(40)) mdl_u (.clk_sys(clk_sys), .reset_n(flash_reset_n),
      .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr),
      .dq_wr(flash_dq_out), .dq_rd(flash_dq_in), .ready_busy_n(flash_ready_busy_n));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // one user request, then a bounded wait for its answer
   task automatic do_op(input logic [2:0] op, input logic [3:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      cmd_op = op;
      cmd_addr = {18'h0, a};
      cmd_wdata = d;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 3000) chk("answer timeout", 16'h1, 16'h0);
   endtask : do_op

   // pin timing watch: reset recovery, gap between accesses, write cycle length
   always @(posedge clk_sys) begin
      ce_q <= flash_ce_n;
      rh_n <= !flash_reset_n ? 0 : rh_n + 1;
      lo_n <= flash_ce_n ? 0 : lo_n + 1;
      hi_n <= flash_ce_n ? hi_n + 1 : 0;
      if (!flash_ce_n && !flash_we_n) wr_seen <= 1'b1;
      if (ce_q && !flash_ce_n) begin
         nfall <= nfall + 1;
         chk("ce high gap", 16'(hi_n >= 1), 16'h1);
         chk("reset recovery", 16'(rh_n >= 2), 16'h1);
      end
      if (!ce_q && flash_ce_n && wr_seen) begin
         chk("write cycle", 16'(lo_n >= 5), 16'h1);
         wr_seen <= 1'b0;
      end
   end

   initial begin
      #200us;
      failures++;
      conclude();
   end

   initial begin
      {rst, cmd_valid, wr_seen, ce_q} = 4'b1001;
      {cmd_op, cmd_addr, cmd_wdata} = '0;
      {failures, num_checks, lo_n, hi_n, rh_n, nfall, n0} = '0;
      rows = '{'{`NFC_OP_WRITE, 4'h3, 16'h5aa5, 16'h0000, 16'h0000, 1'bx},
               '{`NFC_OP_POLL, 4'h3, 16'h0, 16'h0000, 16'h0080, 1'b0},
               '{`NFC_OP_WAIT, 4'h0, 16'h0, 16'h0000, 16'h0000, 1'bx},
               '{`NFC_OP_POLL, 4'h3, 16'h0, 16'h5aa5, 16'hffff, 1'b1},
               '{`NFC_OP_READ, 4'h3, 16'h0, 16'h5aa5, 16'hffff, 1'bx},
               '{`NFC_OP_WRITE, 4'h4, 16'h1234, 16'h0000, 16'h0000, 1'bx},
               '{`NFC_OP_POLL, 4'h8, 16'h0, 16'h0080, 16'h0080, 1'b0}};
      repeat (10) @(negedge clk_sys);
      chk("reset pin in reset", 16'(flash_reset_n), 16'h0);
      chk("ready in reset", 16'(cmd_ready), 16'h0);
      rst = 1'b0;
      // ordinary cases; polls at an unrelated address still see status
      foreach (rows[i]) begin
         n0 = nfall;
         do_op(rows[i].op, rows[i].a, rows[i].d);
         // each status read of a poll is its own chip enable access
         if (rows[i].op == `NFC_OP_POLL) chk("poll accesses", 16'(nfall - n0), 16'h2);
         if (rows[i].msk != 0) chk("row data", rsp_data & rows[i].msk, rows[i].exp);
         if (rows[i].stab !== 1'bx) chk("row stable", 16'(rsp_stable), 16'(rows[i].stab));
      end
      // reset pulse mid-program aborts and frees the busy line
      do_op(`NFC_OP_RESET, 4'h0, 16'h0);
      chk("busy after abort", 16'(flash_ready_busy_n), 16'h1);
      do_op(`NFC_OP_READ, 4'h4, 16'h0);
      chk("aborted word", rsp_data, 16'h1004);
      do_op(`NFC_OP_WAIT, 4'h0, 16'h0);
      chk("idle wait", 16'(flash_ready_busy_n), 16'h1);
      conclude();
   end
endmodule : nfc_ctrl_test
